// ===== hw/crom_map.svh
`ifndef CROM_MAP_SVH
`define CROM_MAP_SVH
// ****************************************
// Geometry and register map constants.
// ****************************************
`define CROM_DEPTH_A 256
`define CROM_SIZE_BITS 2048
`define CROM_AW_A 8
`define CROM_AW_B 7
`define CROM_DW_A 8
`define CROM_DW_B 16
`define CROM_SLICE_DEPTH 512
`define CROM_OFS_CTRL 4'h0
`define CROM_OFS_STAT 4'h4
`define CROM_OFS_DBG 4'h8
`define CROM_CTRL_RST 32'h0000_00F1
`define CROM_B_MODE 0
`define CROM_B_INREG_A 3
`define CROM_B_OUTREG_A 4
`define CROM_B_INREG_B 5
`define CROM_B_OUTREG_B 6
`define CROM_B_CE_IN_A 7
`define CROM_B_CE_OUT_A 8
`define CROM_B_CE_IN_B 9
`define CROM_B_CE_OUT_B 10
`define CROM_B_ACLR_ADR 11
`define CROM_B_ACLR_Q 12
`define CROM_B_SCLR_Q 13
`define CROM_B_RDEN 14
`define CROM_B_FZERO 15
`define CROM_B_TWOPORT 16
`define CROM_B_DBG_VLD 16
`endif

// ===== hw/crom_pkg.sv
// ****************************************
// Types shared by the ROM core.
// ****************************************
package crom_pkg;
  // Clocking scheme, one-hot coded.
  typedef enum logic [2:0] {
    CROM_CLK_SINGLE = 3'b001,
    CROM_CLK_IN_OUT = 3'b010,
    CROM_CLK_PER_PORT = 3'b100
  } crom_clk_mode_type;
  // Which port's dimensions the content image follows.
  typedef enum logic {
    CROM_INIT_A = 1'b0,
    CROM_INIT_B = 1'b1
  } crom_init_type;
endpackage

// ===== hw/crom_core.sv
// Function
// - Single clock mode: one clock, one enable.
// - Input/output mode: address on input, data on output.
// - No write, byte enable or data-in ports.
// - Per-port mode: each port on its clock.
// - Per-port mode: independent enable per port.
// - Address and output registers each optional.
// - Separate enables for input and output registers.
// - Address hold gates only the address register.
// - Asynchronous clear empties selected registers at once.
// - Synchronous clear empties outputs at next edge.
// - Output updates only while read enabled.
// - Force-to-zero drives zeros when read disabled.
// - Contents always come from a build-time image.
// - Single-port image follows first port dimensions.
// - Two-port image follows the selected port.
// - Depth power of two, 32 to 65536.
// - Ports may differ in read width.
// - Physical slices limited in depth.
// - Debug path reads and patches contents independently.
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "crom_map.svh"
module crom_core
  import crom_pkg::*;
#(
  parameter crom_init_type INIT_PORT = CROM_INIT_A
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic primary_clk,
  input wire logic secondary_clk,
  input wire logic clken_primary,
  input wire logic clken_secondary,
  input wire logic in_ce_a,
  input wire logic out_ce_a,
  input wire logic in_ce_b,
  input wire logic out_ce_b,
  input wire logic addr_hold_a,
  input wire logic addr_hold_b,
  input wire logic aclr,
  input wire logic sclr,
  input wire logic rden_a,
  input wire logic rden_b,
  input wire logic [`CROM_AW_A-1:0] addr_a,
  input wire logic [`CROM_AW_B-1:0] addr_b,
  output logic [`CROM_DW_A-1:0] q_a,
  output logic [`CROM_DW_B-1:0] q_b,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata
);

  // ****************************************
  // Content image.
  // ****************************************

  // The image is a constant function so the content is fixed at build time; there is no blank option.
  function automatic logic [`CROM_DW_A-1:0] crom_img_a(input int k);
    crom_img_a = 8'((k * 37 + 11) % 256);
  endfunction

  // Image words when the image is laid out at the second port's width.
  function automatic logic [`CROM_DW_B-1:0] crom_img_b(input int j);
    crom_img_b = 16'((j * 4099 + 23) % 65536);
  endfunction

  // Storage at the narrow word; the wide port reads two neighbours.
  logic [`CROM_DW_A-1:0] rom_mem [`CROM_DEPTH_A];
  // Number of physical slices the array breaks into.
  localparam int SLICES = (`CROM_DEPTH_A + `CROM_SLICE_DEPTH - 1) / `CROM_SLICE_DEPTH;

  // Each entry is wired from the image; depth is a power of two in range.
  genvar gk;
  generate
    for (gk = 0; gk < `CROM_DEPTH_A; gk = gk + 1) begin : g_img
      if (INIT_PORT == CROM_INIT_B) begin : g_b
        // Low byte at the even address, high byte at the odd one.
        // A function result cannot be sliced, so the byte is taken by a shift and a size cast.
        assign rom_mem[gk] = (gk % 2 == 1) ? 8'(crom_img_b(gk / 2) >> 8) : 8'(crom_img_b(gk / 2));
      end else begin : g_a
        assign rom_mem[gk] = crom_img_a(gk);
      end
    end
  endgenerate

  // ****************************************
  // Configuration registers.
  // ****************************************

  logic [31:0] ctrl_q; // Mode and option bits.
  logic [`CROM_AW_A-1:0] dbg_addr_q; // Debug address.
  logic [`CROM_DW_A-1:0] dbg_data_q; // Debug patch data.
  logic dbg_vld_q; // Patch overlay active.
  logic [31:0] reg_rdata_q; // Read data, one cycle late.
  crom_clk_mode_type mode;
  logic opt_inreg_a, opt_outreg_a, opt_inreg_b, opt_outreg_b;
  logic opt_ce_in_a, opt_ce_out_a, opt_ce_in_b, opt_ce_out_b;
  logic opt_aclr_adr, opt_aclr_q, opt_sclr_q, opt_rden, opt_fzero, opt_twoport;

  // Option decode from the control word.
  always_comb begin
    mode = crom_clk_mode_type'(ctrl_q[`CROM_B_MODE +: 3]);
    opt_inreg_a = ctrl_q[`CROM_B_INREG_A];
    opt_outreg_a = ctrl_q[`CROM_B_OUTREG_A];
    opt_inreg_b = ctrl_q[`CROM_B_INREG_B];
    opt_outreg_b = ctrl_q[`CROM_B_OUTREG_B];
    opt_ce_in_a = ctrl_q[`CROM_B_CE_IN_A];
    opt_ce_out_a = ctrl_q[`CROM_B_CE_OUT_A];
    opt_ce_in_b = ctrl_q[`CROM_B_CE_IN_B];
    opt_ce_out_b = ctrl_q[`CROM_B_CE_OUT_B];
    opt_aclr_adr = ctrl_q[`CROM_B_ACLR_ADR];
    opt_aclr_q = ctrl_q[`CROM_B_ACLR_Q];
    opt_sclr_q = ctrl_q[`CROM_B_SCLR_Q];
    opt_rden = ctrl_q[`CROM_B_RDEN];
    opt_fzero = ctrl_q[`CROM_B_FZERO];
    opt_twoport = ctrl_q[`CROM_B_TWOPORT];
  end

  // Control word write; an illegal mode code falls back to single clock.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_q <= `CROM_CTRL_RST;
    end else if (reg_we && reg_addr == `CROM_OFS_CTRL) begin
      ctrl_q <= {15'h0000, reg_wdata[16:3], 3'h1};
      if (reg_wdata[2:0] == 3'h2 || reg_wdata[2:0] == 3'h4) begin
        ctrl_q[2:0] <= reg_wdata[2:0];
      end
    end
  end

  // Debug patch: it swaps in one word without touching the clocking of functional reads.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dbg_addr_q <= 8'h00;
      dbg_data_q <= 8'h00;
      dbg_vld_q <= 1'b0;
    end else if (reg_we && reg_addr == `CROM_OFS_DBG) begin
      dbg_addr_q <= reg_wdata[7:0];
      dbg_data_q <= reg_wdata[15:8];
      dbg_vld_q <= reg_wdata[`CROM_B_DBG_VLD];
    end
  end

  // Content as seen by all readers, with the optional patch applied.
  function automatic logic [`CROM_DW_A-1:0] crom_word(input logic [`CROM_AW_A-1:0] a,
      input logic [`CROM_AW_A-1:0] pa, input logic [`CROM_DW_A-1:0] pd, input logic pv,
      input logic [`CROM_DW_A-1:0] raw);
    crom_word = (pv && a == pa) ? pd : raw;
  endfunction

  // ****************************************
  // Clock qualification.
  // ****************************************

  logic pclk_q, sclk_q; // Previous samples of the two clock pins.
  logic p_edge, s_edge;
  logic tick_in_a, tick_out_a, tick_in_b, tick_out_b;

  // Clock pins are synchronous inputs; a rise on one is an active edge.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pclk_q <= 1'b0;
      sclk_q <= 1'b0;
    end else begin
      pclk_q <= primary_clk;
      sclk_q <= secondary_clk;
    end
  end

  // Route the active edges to each register group by clocking scheme.
  always_comb begin
    p_edge = primary_clk & ~pclk_q & clken_primary;
    s_edge = secondary_clk & ~sclk_q & clken_secondary;
    unique case (mode)
      CROM_CLK_SINGLE: begin
        tick_in_a = p_edge;
        tick_out_a = p_edge;
        tick_in_b = p_edge;
        tick_out_b = p_edge;
      end
      CROM_CLK_IN_OUT: begin
        tick_in_a = p_edge;
        tick_in_b = p_edge;
        tick_out_a = s_edge;
        tick_out_b = s_edge;
      end
      CROM_CLK_PER_PORT: begin
        tick_in_a = p_edge;
        tick_out_a = p_edge;
        tick_in_b = s_edge;
        tick_out_b = s_edge;
      end
      default: begin
        tick_in_a = p_edge;
        tick_out_a = p_edge;
        tick_in_b = p_edge;
        tick_out_b = p_edge;
      end
    endcase
  end

  // ****************************************
  // Address registers.
  // ****************************************

  logic [`CROM_AW_A-1:0] addr_a_q;
  logic [`CROM_AW_B-1:0] addr_b_q;
  logic [`CROM_AW_A-1:0] eff_a;
  logic [`CROM_AW_B-1:0] eff_b;
  logic aclr_adr, aclr_q; // Gated asynchronous clears.
  logic ld_a, ld_b;

  // Only the selected register groups see the asynchronous clear.
  always_comb begin
    aclr_adr = aclr & opt_aclr_adr;
    aclr_q = aclr & opt_aclr_q;
    ld_a = tick_in_a && (in_ce_a || !opt_ce_in_a) && !addr_hold_a;
    ld_b = tick_in_b && (in_ce_b || !opt_ce_in_b) && !addr_hold_b;
  end

  // Address capture; no write data is captured on the ports, as the core has no write port.
  always_ff @(posedge clk or posedge aclr_adr) begin
    if (aclr_adr) begin
      addr_a_q <= 8'h00;
      addr_b_q <= 7'h00;
    end else if (!rst_b) begin
      addr_a_q <= 8'h00;
      addr_b_q <= 7'h00;
    end else begin
      if (ld_a) begin
        addr_a_q <= addr_a;
      end
      if (ld_b) begin
        addr_b_q <= addr_b;
      end
    end
  end

  // ****************************************
  // Read path.
  // ****************************************

  logic [`CROM_DW_A-1:0] rd_a;
  logic [`CROM_DW_B-1:0] rd_b;
  logic en_a, en_b;
  logic [`CROM_AW_A-1:0] lo_b, hi_b;

  // Flow-through addresses skip the register and save a cycle.
  always_comb begin
    eff_a = opt_inreg_a ? addr_a_q : addr_a;
    eff_b = opt_inreg_b ? addr_b_q : addr_b;
    lo_b = {eff_b, 1'b0};
    hi_b = {eff_b, 1'b1};
    rd_a = crom_word(eff_a, dbg_addr_q, dbg_data_q, dbg_vld_q, rom_mem[eff_a]);
    // The wide port shows the same bytes, paired low first.
    rd_b = {crom_word(hi_b, dbg_addr_q, dbg_data_q, dbg_vld_q, rom_mem[hi_b]),
            crom_word(lo_b, dbg_addr_q, dbg_data_q, dbg_vld_q, rom_mem[lo_b])};
    en_a = rden_a || !opt_rden;
    en_b = (rden_b || !opt_rden) && opt_twoport;
  end

  // ****************************************
  // Output registers.
  // ****************************************

  logic [`CROM_DW_A-1:0] q_a_q, hold_a_q;
  logic [`CROM_DW_B-1:0] q_b_q, hold_b_q;
  logic up_a, up_b;

  // Output register update condition per port.
  always_comb begin
    up_a = tick_out_a && (out_ce_a || !opt_ce_out_a);
    up_b = tick_out_b && (out_ce_b || !opt_ce_out_b);
  end

  // Registered read data, with both clears; the clear wins over a read.
  always_ff @(posedge clk or posedge aclr_q) begin
    if (aclr_q) begin
      q_a_q <= 8'h00;
      q_b_q <= 16'h0000;
    end else if (!rst_b) begin
      q_a_q <= 8'h00;
      q_b_q <= 16'h0000;
    end else begin
      if (up_a) begin
        if (sclr && opt_sclr_q) begin
          q_a_q <= 8'h00;
        end else if (en_a) begin
          q_a_q <= rd_a;
        end else if (opt_fzero) begin
          q_a_q <= 8'h00;
        end
      end
      if (up_b) begin
        if (sclr && opt_sclr_q) begin
          q_b_q <= 16'h0000;
        end else if (en_b) begin
          q_b_q <= rd_b;
        end else if (opt_fzero || !opt_twoport) begin
          q_b_q <= 16'h0000;
        end
      end
    end
  end

  // Last flow-through word, kept so an unregistered port can hold while disabled.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hold_a_q <= 8'h00;
      hold_b_q <= 16'h0000;
    end else begin
      if (en_a) begin
        hold_a_q <= rd_a;
      end
      if (en_b) begin
        hold_b_q <= rd_b;
      end
    end
  end

  // Output selection; flow-through output is combinational by nature.
  always_comb begin
    if (opt_outreg_a) begin
      q_a = q_a_q;
    end else if (en_a) begin
      q_a = rd_a;
    end else begin
      q_a = opt_fzero ? 8'h00 : hold_a_q;
    end
    // A single-port build keeps the second port quiet at once, not only after its next edge.
    if (!opt_twoport) begin
      q_b = 16'h0000;
    end else if (opt_outreg_b) begin
      q_b = q_b_q;
    end else if (en_b) begin
      q_b = rd_b;
    end else begin
      q_b = (opt_fzero || !opt_twoport) ? 16'h0000 : hold_b_q;
    end
  end

  // ****************************************
  // Register read back.
  // ****************************************

  // One-cycle read data; the debug read is live content at the debug address.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (reg_re) begin
      unique case (reg_addr)
        `CROM_OFS_CTRL: reg_rdata_q <= ctrl_q;
        `CROM_OFS_STAT: reg_rdata_q <= {8'h00, SLICES[7:0], 1'b0, eff_b, eff_a};
        `CROM_OFS_DBG: reg_rdata_q <= {15'h0000, dbg_vld_q,
            crom_word(dbg_addr_q, dbg_addr_q, dbg_data_q, dbg_vld_q, rom_mem[dbg_addr_q]),
            dbg_addr_q};
        default: reg_rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_q <= 32'h0000_0000;
    end
  end

  // The read port is a plain flip-flop output, so software never sees a decode glitch.
  assign reg_rdata = reg_rdata_q;

endmodule

// ===== verification/crom_monitor.sv
`timescale 1ns/10ps
// ****************************************
// Port checker for the ROM core.
// ****************************************
module crom_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic primary_clk,
  input wire logic clken_primary,
  input wire logic aclr,
  input wire logic sclr,
  input wire logic rden_a,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [7:0] q_a,
  input wire logic [15:0] q_b,
  input wire logic [31:0] reg_rdata
);
  logic [16:0] ctrl_q; // Copy of the control word, kept from bus writes.
  logic pin_q; // Primary pin level one cycle ago.
  logic act; // Qualified active primary edge.
  logic sgl; // Single clock mode with a free-running output register on port A.
  assign act = primary_clk && !pin_q && clken_primary;
  assign sgl = ctrl_q[2:0] == 3'b001 && ctrl_q[4] && !ctrl_q[8];
  // The copy assumes legal mode codes, which is all the bench ever writes.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_q <= 17'h0_00f1;
    end else if (reg_we && reg_addr == 4'h0) begin
      ctrl_q <= reg_wdata[16:0];
    end
  end
  // Edge detection mirrors how the core samples its clock pins.
  always_ff @(posedge clk) begin
    pin_q <= primary_clk;
  end
  a_ctrl_back: assert property (@(posedge clk) disable iff (!rst_b)
    $past(reg_re && reg_addr == 4'h0) |-> reg_rdata[16:0] == $past(ctrl_q)) else $error("control readback wrong");
  a_hole_zero: assert property (@(posedge clk) disable iff (!rst_b)
    $past(reg_re && reg_addr != 4'h0 && reg_addr != 4'h4 && reg_addr != 4'h8) |-> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_idle_zero: assert property (@(posedge clk) disable iff (!rst_b)
    !$past(reg_re) |-> reg_rdata == 32'h0000_0000) else $error("read data not zero when idle");
  a_port_b_off: assert property (@(posedge clk) disable iff (!rst_b)
    !ctrl_q[16] |-> q_b == 16'h0000) else $error("second port active in single port mode");
  a_aclr_now: assert property (@(posedge clk) disable iff (!rst_b)
    aclr && ctrl_q[12] && ctrl_q[4] |-> q_a == 8'h00) else $error("clear did not act at once");
  a_sclr_next: assert property (@(posedge clk) disable iff (!rst_b)
    sgl && act && sclr && ctrl_q[13] |=> q_a == 8'h00) else $error("sync clear missed");
  a_fzero_next: assert property (@(posedge clk) disable iff (!rst_b)
    sgl && act && ctrl_q[15:13] == 3'b110 && !rden_a |=> q_a == 8'h00) else $error("output not forced to zero");
  a_rden_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (sgl && act && ctrl_q[15:13] == 3'b010 && !rden_a && !aclr && !reg_we ##1 !aclr) |-> $stable(q_a))
    else $error("disabled port changed");
  a_quiet_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (sgl && !act && !aclr && !reg_we ##1 !aclr) |-> $stable(q_a)) else $error("output moved without an edge");
endmodule

bind crom_core crom_monitor u_crom_monitor (
  .clk(clk), .rst_b(rst_b), .primary_clk(primary_clk), .clken_primary(clken_primary), .aclr(aclr),
  .sclr(sclr), .rden_a(rden_a), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
  .reg_re(reg_re), .q_a(q_a), .q_b(q_b), .reg_rdata(reg_rdata)
);

// ===== verification/crom_user_model.sv
`timescale 1ns/10ps
// ****************************************
// User logic that clocks the read ports.
// ****************************************
module crom_user_model (
  input wire logic clk,
  output logic primary_clk,
  output logic secondary_clk
);
  // Both pins rest low between requests, like a gated user clock.
  initial begin
    primary_clk = 1'b0;
    secondary_clk = 1'b0;
  end
  // One active edge after lo idle cycles; lo must be at least one so pins never merge.
  task automatic tick(input logic sel, input int lo);
    repeat (lo) @(posedge clk);
    if (sel) secondary_clk <= 1'b1;
    else primary_clk <= 1'b1;
    @(posedge clk);
    primary_clk <= 1'b0;
    secondary_clk <= 1'b0;
  endtask
endmodule

// ===== verification/tb_crom_core.sv
`timescale 1ns/10ps
// ****************************************
// Bench: bus tasks, expectation queues, scenarios.
// ****************************************
module tb_crom_core;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ckp = 1'b1, cks = 1'b1, oce = 1'b1, hold = 1'b0, aclr = 1'b0, sclr = 1'b0, rden = 1'b1, ice = 1'b1;
  logic [7:0] addr_a = 8'h00;
  logic [6:0] addr_b = 7'h00;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_we = 1'b0, reg_re = 1'b0, q_smp = 1'b0, rd_smp = 1'b0;
  logic primary_clk, secondary_clk;
  logic [7:0] q_a;
  logic [15:0] q_b;
  logic [31:0] reg_rdata;
  logic [31:0] rd_exp_q[$]; // Expected register reads, oldest first.
  logic [23:0] q_exp_q[$]; // Expected {q_b, q_a} samples.
  int bad_count = 0, check_count = 0, cyc = 0;
  always #2.5 clk = ~clk;
  crom_core u_crom_core (.clk(clk), .rst_b(rst_b), .primary_clk(primary_clk), .secondary_clk(secondary_clk),
    .clken_primary(ckp), .clken_secondary(cks), .in_ce_a(ice), .out_ce_a(oce), .in_ce_b(ice),
    .out_ce_b(oce), .addr_hold_a(hold), .addr_hold_b(hold), .aclr(aclr), .sclr(sclr), .rden_a(rden),
    .rden_b(rden), .addr_a(addr_a), .addr_b(addr_b), .q_a(q_a), .q_b(q_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));
  crom_user_model u_crom_user_model (.clk(clk), .primary_clk(primary_clk), .secondary_clk(secondary_clk));
  // Content image byte at address k.
  function automatic logic [7:0] img(input int k);
    return 8'((k * 37 + 11) % 256);
  endfunction
  task automatic test_done();
    if (bad_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Strobes drop for a full cycle so no signal is assigned twice in one step.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rd_exp_q.push_back(e);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    @(posedge clk);
  endtask
  task automatic expq(input logic [15:0] eb, input logic [7:0] ea);
    q_exp_q.push_back({eb, ea});
    q_smp <= 1'b1;
    @(posedge clk);
    q_smp <= 1'b0;
    @(posedge clk);
  endtask
  // Random idle gap makes the partner answer promptly or slowly.
  task automatic tick(input logic sel);
    u_crom_user_model.tick(sel, 1 + int'($urandom % 3));
  endtask
  // Watcher: read data stand one cycle after the strobe; q is sampled when flagged.
  always @(posedge clk) begin
    rd_smp <= reg_re;
    if (rd_smp) chk("reg_rdata", reg_rdata, rd_exp_q.pop_front());
    if (q_smp) chk("q_b q_a", {8'h00, q_b, q_a}, {8'h00, q_exp_q.pop_front()});
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    int x, y;
    void'($urandom(32'h93a1_f9bc));
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(4'h0, 32'h0000_00f1);
    wr(4'hc, 32'hffff_ffff);
    rd(4'hc, 32'h0000_0000);
    wr(4'h0, 32'h0001_0079);
    for (int i = 0; i < 4; i++) begin
      x = $urandom % 256;
      y = $urandom % 128;
      addr_a <= 8'(x);
      addr_b <= 7'(y);
      tick(0);
      tick(0);
      expq({img(2 * y + 1), img(2 * y)}, img(x));
    end
    addr_a <= 8'(x ^ 1);
    tick(0);
    hold <= 1'b1;
    addr_a <= 8'(x ^ 2);
    tick(0);
    tick(0);
    expq({img(2 * y + 1), img(2 * y)}, img(x ^ 1));
    hold <= 1'b0;
    wr(4'h0, 32'h0001_0001);
    expq({img(2 * y + 1), img(2 * y)}, img(x ^ 2));
    wr(4'h0, 32'h0001_0051);
    addr_a <= 8'(x);
    tick(0);
    expq({img(2 * y + 1), img(2 * y)}, img(x));
    wr(4'h0, 32'h0000_c079);
    rden <= 1'b0;
    tick(0);
    tick(0);
    expq(16'h0000, 8'h00);
    wr(4'h0, 32'h0000_4079);
    rden <= 1'b1;
    tick(0);
    tick(0);
    expq(16'h0000, img(x));
    rden <= 1'b0;
    addr_a <= 8'(x ^ 3);
    tick(0);
    tick(0);
    expq(16'h0000, img(x));
    rden <= 1'b1;
    wr(4'h0, 32'h0000_2079);
    sclr <= 1'b1;
    tick(0);
    sclr <= 1'b0;
    expq(16'h0000, 8'h00);
    wr(4'h0, 32'h0000_1879);
    tick(0);
    expq(16'h0000, img(x ^ 3));
    aclr <= 1'b1;
    expq(16'h0000, 8'h00);
    aclr <= 1'b0;
    rd(4'h4, 32'h0001_0000);
    wr(4'h0, 32'h0000_0179);
    oce <= 1'b0;
    addr_a <= 8'(x);
    tick(0);
    tick(0);
    expq(16'h0000, 8'h00);
    oce <= 1'b1;
    tick(0);
    expq(16'h0000, img(x));
    wr(4'h0, 32'h0000_00f9);
    ice <= 1'b0;
    addr_a <= 8'(x ^ 5);
    tick(0);
    tick(0);
    expq(16'h0000, img(x));
    ice <= 1'b1;
    wr(4'h0, 32'h0000_007a);
    addr_a <= 8'(x ^ 4);
    tick(0);
    tick(0);
    expq(16'h0000, img(x));
    tick(1);
    expq(16'h0000, img(x ^ 4));
    wr(4'h0, 32'h0001_007c);
    tick(1);
    tick(1);
    expq({img(2 * y + 1), img(2 * y)}, img(x ^ 4));
    cks <= 1'b0;
    addr_b <= 7'(y ^ 1);
    tick(1);
    tick(1);
    expq({img(2 * y + 1), img(2 * y)}, img(x ^ 4));
    cks <= 1'b1;
    addr_a <= 8'(x);
    tick(0);
    tick(0);
    expq({img(2 * y + 1), img(2 * y)}, img(x));
    wr(4'h8, {16'h0001, ~img(x), 8'(x)});
    tick(0);
    expq({img(2 * y + 1), img(2 * y)}, ~img(x));
    rd(4'h8, {16'h0001, ~img(x), 8'(x)});
    wr(4'h8, {24'h00_0000, 8'(x)});
    rd(4'h8, {16'h0000, img(x), 8'(x)});
    test_done();
  end
endmodule
